// *** rtl/nbis_pkg.sv ***
`default_nettype none

package nbis_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned T_EN_CYCLE_NS = 500;
    localparam int unsigned EN_CYCLE_CY = (T_EN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // memories and reset values
    // ------------------------------------------------------------
    localparam int unsigned DISPLAY_DATA_RAM_DEPTH = 80;
    localparam logic [6:0] DISPLAY_DATA_RAM_LAST = 7'h4F;
    localparam logic [6:0] GLYPH_LAST = 7'h3F;
    localparam logic [7:0] BLANK_CHAR = 8'h20;

    // ------------------------------------------------------------
    // initialisation sequence
    // ------------------------------------------------------------
    localparam logic [3:0] INIT_FS_NIBBLE = 4'h2;
    localparam logic [7:0] INIT_FUNC_SET = 8'h20;
    localparam logic [7:0] INIT_DISP_CTL = 8'h0E;
    localparam logic [7:0] INIT_ENTRY = 8'h06;
    localparam logic [1:0] INIT_LAST_STEP = 2'h3;

    // ------------------------------------------------------------
    // instruction decode: leading one selects the opcode
    // ------------------------------------------------------------
    localparam int unsigned OP_DISPLAY_DATA_RAM_BIT = 7;
    localparam int unsigned OP_GLYPH_BIT = 6;
    localparam int unsigned OP_FUNC_BIT = 5;
    localparam int unsigned OP_SHIFT_BIT = 4;
    localparam int unsigned OP_DISP_BIT = 3;
    localparam int unsigned OP_ENTRY_BIT = 2;
    localparam int unsigned OP_HOME_BIT = 1;
    localparam int unsigned OP_CLEAR_BIT = 0;
    localparam int unsigned FS_DL_BIT = 4;
    localparam int unsigned FS_M_BIT = 2;
    localparam int unsigned FS_H_BIT = 0;
    localparam int unsigned DC_D_BIT = 2;
    localparam int unsigned DC_C_BIT = 1;
    localparam int unsigned DC_B_BIT = 0;
    localparam int unsigned EM_ID_BIT = 1;
    localparam int unsigned EM_S_BIT = 0;
    localparam int unsigned SH_SC_BIT = 3;
    localparam int unsigned SH_RL_BIT = 2;
    localparam int unsigned EXT_IM_BIT = 1;
    localparam int unsigned EXT_DM_BIT = 1;
    localparam int unsigned EXT_VGEN_BIT = 0;

    // commands that may damage the part when the LCD supply is external
    function automatic logic nbis_is_hazard(input logic [7:0] b, input logic ext);
        logic vgen;
        logic direct;
        vgen = !b[OP_DISPLAY_DATA_RAM_BIT] && b[OP_GLYPH_BIT] && b[EXT_VGEN_BIT];
        direct = (b[7:3] == 5'h00) && b[OP_ENTRY_BIT] && b[EXT_DM_BIT];
        return ext && (vgen || direct);
    endfunction : nbis_is_hazard

endpackage : nbis_pkg

`default_nettype wire

// *** rtl/nbis_bus_if.sv ***
`default_nettype none

interface nbis_bus_if;
    logic enable;
    logic register_select;
    logic read_write;
    // data_line_7 .. data_line_4
    logic [3:0] data_hi;
    // data_line_3 .. data_line_0, unconnected in nibble mode
    logic [3:0] data_lo;
    logic power_down_pin;

    modport device (
        input enable,
        input register_select,
        input read_write,
        input data_hi,
        input data_lo,
        input power_down_pin
    );

    modport host (
        output enable,
        output register_select,
        output read_write,
        output data_hi,
        output data_lo,
        output power_down_pin
    );
endinterface : nbis_bus_if

`default_nettype wire

// *** rtl/nbis_device.sv ***
`default_nettype none

module nbis_device
    import nbis_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    nbis_bus_if.device bus,
    input wire logic [6:0] rd_index,
    output logic [7:0] rd_data,
    output logic bus_is_8bit,
    output logic nibble_pending,
    output logic display_on,
    output logic cursor_on,
    output logic blink_on,
    output logic two_line,
    output logic ext_set,
    output logic bias_setting_zero,
    output logic icon_only_bit,
    output logic direct_mode,
    output logic vgen_on,
    output logic entry_inc,
    output logic entry_shift,
    output logic ram_is_glyph,
    output logic [6:0] cursor_addr,
    output logic [6:0] shift_ofs,
    output logic exec_pulse,
    output logic exec_rs,
    output logic [7:0] exec_byte,
    output logic display_blank,
    output logic low_power
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic {
        NBIS_ACC_FIRST = 1'b0,
        NBIS_ACC_SECOND = 1'b1
    } nbis_acc_t;

    typedef struct packed {
        logic mode_8bit;
        nbis_acc_t half;
        logic [3:0] hi_nib;
        logic display_on;
        logic cursor_on;
        logic blink_on;
        logic two_line;
        logic ext_set;
        logic bias_zero;
        logic icon_only;
        logic direct_mode;
        logic vgen_on;
        logic entry_inc;
        logic entry_shift;
        logic ram_glyph;
        logic [6:0] addr;
        logic [6:0] shift_ofs;
        logic [DISPLAY_DATA_RAM_DEPTH-1:0][7:0] display_data_ram;
        logic [7:0] rd_data;
        logic exec_pulse;
        logic exec_rs;
        logic [7:0] exec_byte;
        logic display_blank;
        logic low_power;
    } nbis_dev_t;

    nbis_dev_t s_ff;
    nbis_dev_t nxt_s;

    // wraps at the last cell of the selected memory
    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                             input logic [6:0] last);
        logic [6:0] r;
        if (up) begin
            r = (a >= last) ? 7'h00 : 7'(a + 7'h01);
        end else begin
            r = (a == 7'h00) ? last : 7'(a - 7'h01);
        end
        return r;
    endfunction : step_addr

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic go;
        logic [7:0] b;
        logic [6:0] last;
        logic blank_v;
        go = 1'b0;
        b = 8'h00;
        last = s_ff.ram_glyph ? GLYPH_LAST : DISPLAY_DATA_RAM_LAST;
        blank_v = 1'b1;
        nxt_s = s_ff;
        nxt_s.exec_pulse = 1'b0;

        // reads are not served; only writes move the state
        if (bus.enable && !bus.read_write) begin
            if (s_ff.mode_8bit) begin
                // undriven lower lines still count as data here
                go = 1'b1;
                b = {bus.data_hi, bus.data_lo};
            end else if (s_ff.half == NBIS_ACC_FIRST) begin
                nxt_s.hi_nib = bus.data_hi;
                nxt_s.half = NBIS_ACC_SECOND;
            end else begin
                go = 1'b1;
                b = {s_ff.hi_nib, bus.data_hi};
                nxt_s.half = NBIS_ACC_FIRST;
            end
        end

        if (go) begin
            nxt_s.exec_pulse = 1'b1;
            nxt_s.exec_byte = b;
            nxt_s.exec_rs = bus.register_select;
            if (bus.register_select) begin
                // glyph writes move the address, and the shift offset while entry shift is on; no glyph storage kept
                if (!s_ff.ram_glyph) begin
                    nxt_s.display_data_ram[s_ff.addr] = b;
                end
                nxt_s.addr = step_addr(s_ff.addr, s_ff.entry_inc, last);
                if (s_ff.entry_shift) begin
                    nxt_s.shift_ofs = step_addr(s_ff.shift_ofs, s_ff.entry_inc, DISPLAY_DATA_RAM_LAST);
                end
            end else if (b[OP_DISPLAY_DATA_RAM_BIT]) begin
                nxt_s.ram_glyph = 1'b0;
                nxt_s.addr = (b[6:0] > DISPLAY_DATA_RAM_LAST) ? 7'h00 : b[6:0];
            end else if (b[OP_GLYPH_BIT]) begin
                if (s_ff.ext_set) begin
                    nxt_s.vgen_on = b[EXT_VGEN_BIT];
                end else begin
                    nxt_s.ram_glyph = 1'b1;
                    nxt_s.addr = {1'b0, b[5:0]};
                end
            end else if (b[OP_FUNC_BIT]) begin
                // a bus-width change always restarts nibble pairing
                nxt_s.mode_8bit = b[FS_DL_BIT];
                nxt_s.two_line = b[FS_M_BIT];
                nxt_s.ext_set = b[FS_H_BIT];
                nxt_s.bias_zero = 1'b1;
                nxt_s.half = NBIS_ACC_FIRST;
            end else if (b[OP_SHIFT_BIT]) begin
                if (!s_ff.ext_set) begin
                    if (b[SH_SC_BIT]) begin
                        nxt_s.shift_ofs = step_addr(s_ff.shift_ofs, b[SH_RL_BIT], DISPLAY_DATA_RAM_LAST);
                    end else begin
                        nxt_s.addr = step_addr(s_ff.addr, b[SH_RL_BIT], last);
                    end
                end
            end else if (b[OP_DISP_BIT]) begin
                if (s_ff.ext_set) begin
                    nxt_s.icon_only = b[EXT_IM_BIT];
                end else begin
                    nxt_s.display_on = b[DC_D_BIT];
                    nxt_s.cursor_on = b[DC_C_BIT];
                    nxt_s.blink_on = b[DC_B_BIT];
                end
            end else if (b[OP_ENTRY_BIT]) begin
                if (s_ff.ext_set) begin
                    nxt_s.direct_mode = b[EXT_DM_BIT];
                end else begin
                    nxt_s.entry_inc = b[EM_ID_BIT];
                    nxt_s.entry_shift = b[EM_S_BIT];
                end
            end else if (b[OP_HOME_BIT]) begin
                if (!s_ff.ext_set) begin
                    nxt_s.addr = 7'h00;
                    nxt_s.shift_ofs = 7'h00;
                end
            end else if (b[OP_CLEAR_BIT]) begin
                if (!s_ff.ext_set) begin
                    for (int i = 0; i < DISPLAY_DATA_RAM_DEPTH; i++) begin
                        nxt_s.display_data_ram[i] = BLANK_CHAR;
                    end
                    nxt_s.addr = 7'h00;
                    nxt_s.shift_ofs = 7'h00;
                    nxt_s.entry_inc = 1'b1;
                    nxt_s.ram_glyph = 1'b0;
                end
            end
        end

        // blank while off or while every cell holds a space
        for (int i = 0; i < DISPLAY_DATA_RAM_DEPTH; i++) begin
            if (nxt_s.display_data_ram[i] != BLANK_CHAR) begin
                blank_v = 1'b0;
            end
        end
        nxt_s.display_blank = blank_v || !nxt_s.display_on;
        nxt_s.low_power = nxt_s.icon_only || !nxt_s.display_on || nxt_s.direct_mode
                          || bus.power_down_pin;
        nxt_s.rd_data = (rd_index <= DISPLAY_DATA_RAM_LAST) ? s_ff.display_data_ram[rd_index] : 8'h00;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_ff <= '0;
            s_ff.mode_8bit <= 1'b1;
            s_ff.entry_inc <= 1'b1;
            s_ff.display_blank <= 1'b1;
            s_ff.low_power <= 1'b1;
            for (int i = 0; i < DISPLAY_DATA_RAM_DEPTH; i++) begin
                s_ff.display_data_ram[i] <= BLANK_CHAR;
            end
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_data = s_ff.rd_data;
    assign bus_is_8bit = s_ff.mode_8bit;
    assign nibble_pending = (s_ff.half == NBIS_ACC_SECOND);
    assign display_on = s_ff.display_on;
    assign cursor_on = s_ff.cursor_on;
    assign blink_on = s_ff.blink_on;
    assign two_line = s_ff.two_line;
    assign ext_set = s_ff.ext_set;
    assign bias_setting_zero = s_ff.bias_zero;
    assign icon_only_bit = s_ff.icon_only;
    assign direct_mode = s_ff.direct_mode;
    assign vgen_on = s_ff.vgen_on;
    assign entry_inc = s_ff.entry_inc;
    assign entry_shift = s_ff.entry_shift;
    assign ram_is_glyph = s_ff.ram_glyph;
    assign cursor_addr = s_ff.addr;
    assign shift_ofs = s_ff.shift_ofs;
    assign exec_pulse = s_ff.exec_pulse;
    assign exec_rs = s_ff.exec_rs;
    assign exec_byte = s_ff.exec_byte;
    assign display_blank = s_ff.display_blank;
    assign low_power = s_ff.low_power;

endmodule : nbis_device

`default_nettype wire

// *** rtl/nbis_host.sv ***
`default_nettype none

module nbis_host
    import nbis_pkg::*;
#(
    parameter int unsigned GAP_CY = EN_CYCLE_CY
)
(
    input wire logic mclk,
    input wire logic rst,
    nbis_bus_if.host bus,
    input wire logic ext_lcd_supply,
    input wire logic power_down_req,
    input wire logic cmd_valid,
    input wire logic cmd_rs,
    input wire logic [7:0] cmd_byte,
    output logic cmd_ready,
    output logic cmd_refused,
    output logic init_done
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        NBIS_HS_INIT = 3'b000,
        NBIS_HS_HI = 3'b001,
        NBIS_HS_GAP = 3'b010,
        NBIS_HS_LO = 3'b011,
        NBIS_HS_IDLE = 3'b100
    } nbis_hst_t;

    typedef struct packed {
        nbis_hst_t st;
        logic [1:0] step;
        logic in_init;
        logic [7:0] byte_q;
        logic two;
        logic lo_next;
        logic [7:0] gap;
        logic ext_set;
        logic en;
        logic rs;
        logic [3:0] hi;
        logic pd;
        logic ready;
        logic refused;
        logic done;
    } nbis_host_t;

    localparam logic [7:0] GAP_LAST = 8'(GAP_CY - 1);

    nbis_host_t s_ff;
    nbis_host_t nxt_s;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.en = 1'b0;
        nxt_s.refused = 1'b0;
        nxt_s.pd = power_down_req;
        case (s_ff.st)
            NBIS_HS_INIT: begin
                nxt_s.rs = 1'b0;
                nxt_s.two = 1'b1;
                case (s_ff.step)
                    2'h0: begin
                        // lone nibble taken as a full byte by the 8-bit bus
                        nxt_s.byte_q = {INIT_FS_NIBBLE, 4'h0};
                        nxt_s.two = 1'b0;
                    end
                    2'h1: nxt_s.byte_q = INIT_FUNC_SET;
                    2'h2: nxt_s.byte_q = INIT_DISP_CTL;
                    default: nxt_s.byte_q = INIT_ENTRY;
                endcase
                // lines settle a cycle ahead of the strobe for set-up margin
                nxt_s.hi = nxt_s.byte_q[7:4];
                nxt_s.st = NBIS_HS_HI;
            end
            NBIS_HS_HI: begin
                nxt_s.en = 1'b1;
                nxt_s.lo_next = s_ff.two;
                nxt_s.gap = 8'h00;
                nxt_s.st = NBIS_HS_GAP;
            end
            NBIS_HS_LO: begin
                nxt_s.en = 1'b1;
                nxt_s.lo_next = 1'b0;
                nxt_s.gap = 8'h00;
                nxt_s.st = NBIS_HS_GAP;
            end
            NBIS_HS_GAP: begin
                // spacing keeps every strobe past the enable cycle time
                if (s_ff.gap < GAP_LAST) begin
                    nxt_s.gap = 8'(s_ff.gap + 8'h01);
                end else if (s_ff.lo_next) begin
                    nxt_s.hi = s_ff.byte_q[3:0];
                    nxt_s.st = NBIS_HS_LO;
                end else if (s_ff.in_init && s_ff.step != INIT_LAST_STEP) begin
                    nxt_s.step = 2'(s_ff.step + 2'h1);
                    nxt_s.st = NBIS_HS_INIT;
                end else begin
                    nxt_s.in_init = 1'b0;
                    nxt_s.done = 1'b1;
                    nxt_s.ready = 1'b1;
                    nxt_s.st = NBIS_HS_IDLE;
                end
            end
            NBIS_HS_IDLE: begin
                if (cmd_valid && s_ff.ready) begin
                    if (!cmd_rs && ext_lcd_supply && nbis_is_hazard(cmd_byte, s_ff.ext_set)) begin
                        nxt_s.refused = 1'b1;
                    end else begin
                        nxt_s.byte_q = cmd_byte;
                        nxt_s.rs = cmd_rs;
                        nxt_s.hi = cmd_byte[7:4];
                        nxt_s.two = 1'b1;
                        nxt_s.ready = 1'b0;
                        if (!cmd_rs && cmd_byte[7:6] == 2'h0 && cmd_byte[OP_FUNC_BIT]) begin
                            nxt_s.ext_set = cmd_byte[FS_H_BIT];
                        end
                        nxt_s.st = NBIS_HS_HI;
                    end
                end
            end
            default: begin
                nxt_s.st = NBIS_HS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_ff <= '0;
            s_ff.st <= NBIS_HS_INIT;
            s_ff.in_init <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign bus.enable = s_ff.en;
    assign bus.register_select = s_ff.rs;
    assign bus.read_write = 1'b0;
    assign bus.data_hi = s_ff.hi;
    assign bus.data_lo = 4'h0;
    assign bus.power_down_pin = s_ff.pd;
    assign cmd_ready = s_ff.ready;
    assign cmd_refused = s_ff.refused;
    assign init_done = s_ff.done;

endmodule : nbis_host

`default_nettype wire

// *** tb/nbis_bus_chk.sv ***
`default_nettype none

module nbis_bus_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic enable,
    input wire logic register_select,
    input wire logic read_write,
    input wire logic [3:0] data_hi,
    input wire logic [3:0] data_lo,
    input wire logic power_down_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // strobe count since reset, saturating
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] cnt;
    } nbis_chk_t;

    nbis_chk_t st_ff;
    nbis_chk_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (rst) begin
            nxt_st.cnt = 3'h0;
        end else if (enable && st_ff.cnt != 3'h7) begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        st_ff <= nxt_st;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_write_only: assert property (read_write == 1'b0)
        else $error("host drove a read access");
    a_lo_lines_zero: assert property (data_lo == 4'h0)
        else $error("lower data lines not quiet");
    a_strobe_pulse: assert property (enable |=> !enable)
        else $error("strobe wider than one cycle");
    a_setup_stable: assert property (enable |-> $stable(data_hi) && $stable(register_select))
        else $error("bus changed on strobe cycle");
    a_hold_stable: assert property (enable |=> $stable(data_hi) && $stable(register_select))
        else $error("bus changed right after strobe");
    a_init_first: assert property (enable && st_ff.cnt == 3'h0 |-> data_hi == 4'h2)
        else $error("first access not interface select");
    a_fs_repeat: assert property (enable && st_ff.cnt == 3'h1 |-> data_hi == 4'h2 ##1
        !enable [*1] ##[1:300] enable && data_hi == 4'h0)
        else $error("function set not sent twice");
    a_disp_ctl: assert property (enable && st_ff.cnt == 3'h3 |-> data_hi == 4'h0 ##1
        !enable ##[1:300] enable && data_hi == 4'hE)
        else $error("display control nibbles wrong");
    a_entry_mode: assert property (enable && st_ff.cnt == 3'h5 |-> data_hi == 4'h0 ##1
        !enable ##[1:300] enable && data_hi == 4'h6)
        else $error("entry mode nibbles wrong");
    a_init_instr: assert property (enable && st_ff.cnt != 3'h7 |-> !register_select)
        else $error("init access not an instruction");

    c_init_done: cover property (enable && st_ff.cnt == 3'h6);
    c_data_strobe: cover property (enable && register_select);
    c_power_down: cover property ($rose(power_down_pin));
endmodule : nbis_bus_chk

`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none

module tb;
    import nbis_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ext_lcd_supply = 1'b0;
    logic power_down_req = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_rs = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic [6:0] rd_index = 7'h00;
    logic cmd_ready, cmd_refused, init_done;
    logic [7:0] rd_data, exec_byte;
    logic bus_is_8bit, nibble_pending, display_on, cursor_on, blink_on, two_line, ext_set;
    logic bias_setting_zero, icon_only_bit, direct_mode, vgen_on, entry_inc, entry_shift;
    logic ram_is_glyph, exec_pulse, exec_rs, display_blank, low_power;
    logic [6:0] cursor_addr, shift_ofs;
    int miscompares = 0;
    int checks_done = 0;
    int n_exec = 0;
    int seed = 32'h451ccf80;
    logic [7:0] exec_log[$];

    always #50 mclk = ~mclk;

    nbis_bus_if bus_if ();

    nbis_host nbis_host_inst (.mclk(mclk), .rst(rst), .bus(bus_if.host),
        .ext_lcd_supply(ext_lcd_supply), .power_down_req(power_down_req),
        .cmd_valid(cmd_valid), .cmd_rs(cmd_rs), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
        .cmd_refused(cmd_refused), .init_done(init_done));

    nbis_device nbis_device_inst (.mclk(mclk), .rst(rst), .bus(bus_if.device),
        .rd_index(rd_index), .rd_data(rd_data), .bus_is_8bit(bus_is_8bit),
        .nibble_pending(nibble_pending), .display_on(display_on), .cursor_on(cursor_on),
        .blink_on(blink_on), .two_line(two_line), .ext_set(ext_set),
        .bias_setting_zero(bias_setting_zero), .icon_only_bit(icon_only_bit),
        .direct_mode(direct_mode), .vgen_on(vgen_on), .entry_inc(entry_inc),
        .entry_shift(entry_shift), .ram_is_glyph(ram_is_glyph), .cursor_addr(cursor_addr),
        .shift_ofs(shift_ofs), .exec_pulse(exec_pulse), .exec_rs(exec_rs),
        .exec_byte(exec_byte), .display_blank(display_blank), .low_power(low_power));

    nbis_bus_chk nbis_bus_chk_inst (.mclk(mclk), .rst(rst), .enable(bus_if.enable),
        .register_select(bus_if.register_select), .read_write(bus_if.read_write),
        .data_hi(bus_if.data_hi), .data_lo(bus_if.data_lo),
        .power_down_pin(bus_if.power_down_pin));

    always @(posedge mclk) begin
        if (exec_pulse === 1'b1) begin
            n_exec++;
            exec_log.push_back(exec_byte);
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_init(input int idx);
        logic [7:0] seq[4];
        seq = '{INIT_FUNC_SET, INIT_FUNC_SET, INIT_DISP_CTL, INIT_ENTRY};
        return seq[idx];
    endfunction : exp_init

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic wait_ready();
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 200) begin
            @(posedge mclk);
            #1;
            k++;
        end
        chk("ready", 32'(cmd_ready), 32'h1);
    endtask : wait_ready

    // refused commands must leave the device untouched
    task automatic send(input logic rs, input logic [7:0] b, input logic refuse);
        int n0;
        wait_ready();
        n0 = n_exec;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_rs <= rs;
        cmd_byte <= b;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        #1;
        chk("refused", 32'(cmd_refused), 32'(refuse));
        wait_ready();
        repeat (2) @(posedge mclk);
        #1;
        chk("exec count", 32'(n_exec - n0), refuse ? 32'h0 : 32'h1);
        if (!refuse) begin
            chk("exec byte", 32'(exec_byte), 32'(b));
            chk("exec kind", 32'(exec_rs), 32'(rs));
        end
    endtask : send

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        end_sim();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin : main
        int k;
        logic [6:0] a;
        logic [7:0] d;
        repeat (5) @(posedge mclk);
        #1;
        chk("bus 8bit at reset", 32'(bus_is_8bit), 32'h1);
        chk("blank at reset", 32'(display_blank), 32'h1);
        @(posedge mclk);
        rst <= 1'b0;
        k = 0;
        while (init_done !== 1'b1 && k < 500) begin
            @(posedge mclk);
            #1;
            k++;
        end
        repeat (2) @(posedge mclk);
        #1;
        chk("init done", 32'(init_done), 32'h1);
        chk("init exec count", 32'(exec_log.size()), 32'h4);
        for (int i = 0; i < 4 && i < exec_log.size(); i++) begin
            chk("init byte", 32'(exec_log[i]), 32'(exp_init(i)));
        end
        chk("bus 8bit", 32'(bus_is_8bit), 32'h0);
        chk("two line", 32'(two_line), 32'h0);
        chk("bias zero", 32'(bias_setting_zero), 32'h1);
        chk("display on", 32'({display_on, cursor_on, blink_on}), 32'h6);
        chk("blank", 32'(display_blank), 32'h1);
        chk("entry", 32'({entry_inc, entry_shift}), 32'h2);
        chk("low power", 32'(low_power), 32'h0);
        $display("test init done");

        send(1'b1, 8'h50, 1'b0);
        chk("cursor", 32'(cursor_addr), 32'h1);
        chk("ram sel", 32'(ram_is_glyph), 32'h0);
        @(posedge mclk) rd_index <= 7'h00;
        repeat (2) @(posedge mclk);
        #1;
        chk("ram cell", 32'(rd_data), 32'h50);
        chk("not blank", 32'(display_blank), 32'h0);
        chk("pending", 32'(nibble_pending), 32'h0);
        for (int i = 0; i < 16; i++) begin
            a = 7'($unsigned($random(seed)) % 60);
            d = 8'($random(seed));
            send(1'b0, 8'h80 | {1'b0, a}, 1'b0);
            send(1'b1, d, 1'b0);
            chk("cursor step", 32'(cursor_addr), 32'(a) + 32'h1);
            @(posedge mclk) rd_index <= a;
            repeat (2) @(posedge mclk);
            #1;
            chk("ram cell", 32'(rd_data), 32'(d));
        end
        chk("no shift", 32'(shift_ofs), 32'h0);
        $display("test data done");

        send(1'b0, 8'h08, 1'b0);
        chk("display off saves", 32'({display_on, low_power}), 32'h1);
        send(1'b0, 8'h0E, 1'b0);
        chk("display on", 32'(low_power), 32'h0);
        send(1'b0, 8'h21, 1'b0);
        chk("ext set", 32'(ext_set), 32'h1);
        send(1'b0, 8'h0A, 1'b0);
        chk("icon saves", 32'({icon_only_bit, low_power}), 32'h3);
        send(1'b0, 8'h08, 1'b0);
        send(1'b0, 8'h06, 1'b0);
        chk("direct saves", 32'({direct_mode, low_power}), 32'h3);
        send(1'b0, 8'h04, 1'b0);
        chk("direct off", 32'({direct_mode, low_power}), 32'h0);
        @(posedge mclk) ext_lcd_supply <= 1'b1;
        send(1'b0, 8'h41, 1'b1);
        send(1'b0, 8'h06, 1'b1);
        chk("no gen no direct", 32'({vgen_on, direct_mode}), 32'h0);
        @(posedge mclk) ext_lcd_supply <= 1'b0;
        send(1'b0, 8'h41, 1'b0);
        chk("gen on", 32'(vgen_on), 32'h1);
        send(1'b0, 8'h40, 1'b0);
        send(1'b0, 8'h20, 1'b0);
        chk("basic set", 32'({ext_set, bus_is_8bit}), 32'h0);
        send(1'b0, 8'h01, 1'b0);
        chk("clear blank", 32'({display_blank, cursor_addr}), 32'h80);
        @(posedge mclk) power_down_req <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk("pin saves", 32'({bus_if.power_down_pin, low_power}), 32'h3);
        @(posedge mclk) power_down_req <= 1'b0;
        $display("test power done");
        end_sim();
    end
endmodule : tb

`default_nettype wire
